// File: rtl/emulator_break_gating.sv
// run/break gating of an emulator around a target mcu
// assumes apb from the emulation controller and user control pins asynchronous
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
module emulator_break_gating
    import break_gating_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // emulation controller events
    input wire logic I_BREAK_HIT,
    input wire logic I_STEP_DONE,
    // user system control pins, active low
    input wire logic I_EXT_RESET_IN_N,
    input wire logic I_BUS_REQUEST_IN_N,
    input wire logic I_WAIT_IN_N,
    // to the mcu
    output logic O_MCU_RESET_N,
    output logic O_MCU_BUS_REQUEST_N,
    output logic O_MCU_WAIT_N,
    input wire logic [IRQ_W-1:0] I_IRQ_SRC,
    output logic [IRQ_W-1:0] O_MCU_IRQ,
    input wire logic [31:0] I_PON_PC_VEC,
    input wire logic [31:0] I_PON_SP_VEC,
    output reg_load_t O_REG_LOAD,
    // module enables, break flag and guard counter outputs
    output logic O_BREAK,
    output logic O_USER_BREAK_EN,
    output logic O_PERIPH_RUN,
    output logic O_GUARD_TICK,
    output logic O_GUARD_OVF,
    output logic [7:0] O_GUARD_COUNT,
    output logic O_TRACE_USER_EN,
    output logic O_TRACE_EMU_EN,
    output logic O_SDBG_USER_EN,
    output logic O_SDBG_EMU_EN
);

    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        emu_state_t mode;
        logic [2:0] dis;
        logic trace_claim;
        logic cmd_rst;
        logic [7:0] psc_div;
        logic [7:0] psc_cnt;
        logic tick;
        logic [7:0] guard_count_value;
        logic guard_ovf;
        logic ube;
        logic [2:0] gated_n;
        logic [IRQ_W-1:0] irq_hold;
        logic [IRQ_W-1:0] irq_out;
        logic [31:0] prdata;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;
    logic [2:0] pins_q;
    logic brk;
    logic wr_acc;
    logic setup;

    // address decode used by the error answer only; the read path decodes in its own case
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == GUARD_CFG_OFS);
    endfunction : addr_hit

    // pass mask of the three control inputs for a given mode and settings
    function automatic logic [2:0] pass_mask(input emu_state_t m, input logic [2:0] d);
        pass_mask = 3'h0;
        case (m)
            EMU_RUN: pass_mask = ~d;
            EMU_STEP: pass_mask = ~d & 3'h6;
            EMU_MEMACC: pass_mask = 3'h6;
            EMU_BREAK: pass_mask = 3'h0;
            default: pass_mask = 3'h0;
        endcase
    endfunction : pass_mask

    // ***************************************************************
    // submodules
    // ***************************************************************
    pin_sync #(
        .W(3),
        .RST_VAL(PIN_IDLE_VAL)
    ) u_pin_sync (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_pin({I_WAIT_IN_N, I_BUS_REQUEST_IN_N, I_EXT_RESET_IN_N}),
        .o_q(pins_q)
    );

    reg_init_loader u_loader (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_cmd_reset(s_reg.cmd_rst),
        .i_pc_vec(I_PON_PC_VEC),
        .i_sp_vec(I_PON_SP_VEC),
        .o_load(O_REG_LOAD)
    );

    // single break signal for the guard, user break and interrupt gates
    assign brk = (s_reg.mode == EMU_BREAK);
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign setup = PSEL && !PENABLE;

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.cmd_rst = 1'b0;
        s_next.tick = 1'b0;
        s_next.guard_ovf = 1'b0;
        // register writes
        if (wr_acc && PADDR == CTRL_OFS) begin
            s_next.mode = emu_state_t'(PWDATA[CTRL_MODE_LSB +: 2]);
            s_next.dis = PWDATA[CTRL_DIS_LSB +: 3];
            s_next.trace_claim = PWDATA[CTRL_TRACE_BIT];
            s_next.cmd_rst = PWDATA[CTRL_CPURST_BIT];
        end
        if (wr_acc && PADDR == GUARD_CFG_OFS) begin
            s_next.psc_div = PWDATA[GCFG_DIV_LSB +: 8];
        end
        // hardware break wins over a software mode write except in memory access mode
        if (I_BREAK_HIT && s_reg.mode != EMU_MEMACC) begin
            s_next.mode = EMU_BREAK;
        end else if (I_STEP_DONE && s_reg.mode == EMU_STEP) begin
            s_next.mode = EMU_BREAK;
        end
        // prescaler free runs in every mode
        if (s_reg.psc_cnt >= s_reg.psc_div) begin
            s_next.psc_cnt = 8'h00;
            s_next.tick = 1'b1;
        end else begin
            s_next.psc_cnt = s_reg.psc_cnt + 8'h01;
        end
        // guard counter counts only outside break
        if (s_reg.tick && !brk) begin
            s_next.guard_count_value = s_reg.guard_count_value + 8'h01;
            s_next.guard_ovf = (s_reg.guard_count_value == GUARD_MAX);
        end
        s_next.ube = !brk;
        // gated control pins, idle high when blocked
        s_next.gated_n = pins_q | ~pass_mask(s_reg.mode, s_reg.dis);
        // interrupts retained in break and released on restart
        if (brk) begin
            s_next.irq_hold = s_reg.irq_hold | I_IRQ_SRC;
            s_next.irq_out = '0;
        end else begin
            s_next.irq_hold = '0;
            s_next.irq_out = I_IRQ_SRC | s_reg.irq_hold;
        end
        // read data captured in the setup cycle
        if (setup && !PWRITE) begin
            s_next.prdata = 32'h00000000;
            case (PADDR)
                CTRL_OFS: begin
                    s_next.prdata[CTRL_MODE_LSB +: 2] = s_reg.mode;
                    s_next.prdata[CTRL_DIS_LSB +: 3] = s_reg.dis;
                    s_next.prdata[CTRL_TRACE_BIT] = s_reg.trace_claim;
                end
                STATUS_OFS: begin
                    s_next.prdata[STAT_MODE_LSB +: 2] = s_reg.mode;
                    s_next.prdata[STAT_BRK_BIT] = brk;
                    s_next.prdata[STAT_COUNT_LSB +: 8] = s_reg.guard_count_value;
                end
                GUARD_CFG_OFS: begin
                    s_next.prdata[GCFG_DIV_LSB +: 8] = s_reg.psc_div;
                end
                default: begin
                    s_next.prdata = 32'h00000000;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s_reg <= '0;
            s_reg.mode <= EMU_BREAK;
            s_reg.dis <= DIS_RST_VAL;
            s_reg.psc_div <= PSC_DIV_RST_VAL;
            s_reg.gated_n <= PIN_IDLE_VAL;
        end else begin
            s_reg <= s_next;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign PRDATA = s_reg.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
    assign O_MCU_RESET_N = s_reg.gated_n[PIN_RST];
    assign O_MCU_BUS_REQUEST_N = s_reg.gated_n[PIN_BUS_REQUEST_IN];
    assign O_MCU_WAIT_N = s_reg.gated_n[PIN_WAIT];
    assign O_MCU_IRQ = s_reg.irq_out;
    assign O_BREAK = brk;
    assign O_USER_BREAK_EN = s_reg.ube;
    assign O_PERIPH_RUN = I_RSTN;
    assign O_GUARD_TICK = s_reg.tick;
    assign O_GUARD_OVF = s_reg.guard_ovf;
    assign O_GUARD_COUNT = s_reg.guard_count_value;
    assign O_TRACE_USER_EN = !s_reg.trace_claim;
    assign O_TRACE_EMU_EN = s_reg.trace_claim;
    assign O_SDBG_USER_EN = 1'b0;
    assign O_SDBG_EMU_EN = 1'b1;

    // ***************************************************************
    // assertions
    // ***************************************************************
    // gating of the control inputs and mode changes
    a_step_no_reset: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.mode != EMU_RUN) |=> O_MCU_RESET_N)
        else $error("reset passed outside run");
    a_run_reset_pass: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.mode == EMU_RUN && !s_reg.dis[PIN_RST])
        |=> O_MCU_RESET_N == $past(pins_q[PIN_RST]))
        else $error("reset not passed in run");
    a_memacc_pass: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.mode == EMU_MEMACC) |=> O_MCU_WAIT_N == $past(pins_q[PIN_WAIT])
        && O_MCU_BUS_REQUEST_N == $past(pins_q[PIN_BUS_REQUEST_IN]))
        else $error("bus_request_in or wait blocked in memory access");
    a_break_block: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        brk |=> O_MCU_RESET_N && O_MCU_BUS_REQUEST_N && O_MCU_WAIT_N)
        else $error("control input reached mcu in break");
    a_disable_wait: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.dis[PIN_WAIT] && s_reg.mode inside {EMU_RUN, EMU_STEP}) |=> O_MCU_WAIT_N)
        else $error("disabled wait passed");
    a_disable_bus_request_in: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.dis[PIN_BUS_REQUEST_IN] && s_reg.mode inside {EMU_RUN, EMU_STEP}) |=> O_MCU_BUS_REQUEST_N)
        else $error("disabled bus request passed");
    a_disable_reset: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.dis[PIN_RST] && s_reg.mode inside {EMU_RUN, EMU_STEP}) |=> O_MCU_RESET_N)
        else $error("disabled reset passed");
    a_memacc_no_break: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (I_BREAK_HIT && s_reg.mode == EMU_MEMACC && !(wr_acc && PADDR == CTRL_OFS))
        |=> s_reg.mode == EMU_MEMACC)
        else $error("break hit left memory access");
    a_step_done: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (I_STEP_DONE && s_reg.mode == EMU_STEP) |=> brk)
        else $error("step end did not break");
    // guard counter and its prescaler
    a_guard_freeze: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        brk |=> $stable(O_GUARD_COUNT))
        else $error("guard counter moved in break");
    a_guard_count: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.tick && !brk) |=> O_GUARD_COUNT == $past(O_GUARD_COUNT) + 8'h01)
        else $error("guard counter missed a tick");
    a_ovf_wrap: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_GUARD_OVF |-> O_GUARD_COUNT == 8'h00)
        else $error("overflow pulse without wrap");
    a_psc_runs: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (s_reg.psc_cnt < s_reg.psc_div && !(wr_acc && PADDR == GUARD_CFG_OFS))
        |=> s_reg.psc_cnt == $past(s_reg.psc_cnt) + 8'h01)
        else $error("prescaler stalled");
    // module enables, port ownership and held interrupts
    a_ube_gate: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        ##1 O_USER_BREAK_EN == !$past(brk))
        else $error("user break unit enable wrong");
    a_trace_owner: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !(O_TRACE_USER_EN && O_TRACE_EMU_EN) && !O_SDBG_USER_EN)
        else $error("debug port ownership clash");
    a_irq_restart: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (!brk && s_reg.irq_hold != '0) |=> (O_MCU_IRQ & $past(s_reg.irq_hold)) != '0)
        else $error("held interrupt not released");
    a_irq_break_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        brk |=> O_MCU_IRQ == '0)
        else $error("interrupt reached mcu in break");

    c_run_reset: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        s_reg.mode == EMU_RUN && !O_MCU_RESET_N);
    c_break_hit: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        s_reg.mode == EMU_RUN ##1 brk);
    c_guard_ovf: cover property (@(posedge I_CLK) disable iff (!I_RSTN) O_GUARD_OVF);
    c_cmd_reset: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        O_REG_LOAD.strobe && !O_REG_LOAD.power_on);

endmodule : emulator_break_gating

// File: rtl/break_gating_pkg.sv
// shared constants and carriers of the emulator break gating block
// assumes a single 40 MHz clock and an APB register port with 32-bit data
package break_gating_pkg;

    // ***************************************************************
    // register map (byte addresses)
    // ***************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] GUARD_CFG_OFS = 8'h08;

    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIS_LSB = 2;
    localparam int CTRL_TRACE_BIT = 5;
    localparam int CTRL_CPURST_BIT = 8;
    // status fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_BRK_BIT = 2;
    localparam int STAT_COUNT_LSB = 8;
    // guard cfg fields
    localparam int GCFG_DIV_LSB = 0;

    // ***************************************************************
    // reset and initial values
    // ***************************************************************
    localparam logic [2:0] DIS_RST_VAL = 3'h0;
    localparam logic [7:0] PSC_DIV_RST_VAL = 8'h0f;
    localparam logic [2:0] PIN_IDLE_VAL = 3'h7;
    localparam logic [31:0] STATUS_WORD_INIT = 32'h000000f0;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [7:0] GUARD_MAX = 8'hff;
    localparam int IRQ_W = 4;

    // control input index within the 3-bit pin group
    localparam int PIN_RST = 0;
    localparam int PIN_BUS_REQUEST_IN = 1;
    localparam int PIN_WAIT = 2;

    // ***************************************************************
    // types
    // ***************************************************************
    typedef enum logic [1:0] {
        EMU_BREAK = 2'b00,
        EMU_RUN = 2'b01,
        EMU_STEP = 2'b10,
        EMU_MEMACC = 2'b11
    } emu_state_t;

    typedef struct packed {
        logic strobe;
        logic power_on;
        logic load_all;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] status_word;
        logic [31:0] vector_base_pointer;
        logic [31:0] global_base_pointer;
        logic [31:0] multiply_acc_high;
        logic [31:0] multiply_acc_low;
        logic [31:0] return_pointer;
        logic [31:0] gpr_value;
    } reg_load_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : break_gating_pkg

// File: rtl/pin_sync.sv
// three-flop synchroniser for user-system control pins
// assumes pins are asynchronous to i_clk; output follows once stages 2 and 3 agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // shift chain; ff1 is read only by ff2
    always_comb begin
        s_next = s_reg;
        s_next.ff1 = i_pin;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        for (int i = 0; i < W; i++) begin
            if (s_reg.ff2[i] == s_reg.ff3[i]) begin
                s_next.q[i] = s_reg.ff3[i];
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_q = s_reg.q;

    a_sync_agree: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s_reg.ff2 == s_reg.ff3) |=> (o_q == $past(s_reg.ff3)))
        else $error("sync output did not follow agreed stages");

endmodule : pin_sync

// File: rtl/reg_init_loader.sv
// loads cpu register initial values at power-on and on command cpu reset
// assumes vector values are stable on i_clk when a load is triggered
`timescale 1ns/10ps
module reg_init_loader
    import break_gating_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cmd_reset,
    input wire logic [31:0] i_pc_vec,
    input wire logic [31:0] i_sp_vec,
    output reg_load_t o_load
);

    typedef struct packed {
        logic pon_pend;
        reg_load_t load;
    } loader_state_t;

    loader_state_t s_reg;
    loader_state_t s_next;

    // power-on load fires on the first edge after reset release
    always_comb begin
        s_next = s_reg;
        s_next.load.strobe = 1'b0;
        if (s_reg.pon_pend || i_cmd_reset) begin
            s_next.pon_pend = 1'b0;
            s_next.load.strobe = 1'b1;
            s_next.load.power_on = s_reg.pon_pend;
            s_next.load.load_all = s_reg.pon_pend;
            s_next.load.pc = i_pc_vec;
            s_next.load.sp = i_sp_vec;
            s_next.load.status_word = STATUS_WORD_INIT;
            s_next.load.vector_base_pointer = ZERO_WORD;
            s_next.load.global_base_pointer = ZERO_WORD;
            s_next.load.multiply_acc_high = ZERO_WORD;
            s_next.load.multiply_acc_low = ZERO_WORD;
            s_next.load.return_pointer = ZERO_WORD;
            s_next.load.gpr_value = ZERO_WORD;
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
            s_reg.pon_pend <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_load = s_reg.load;

    a_pon_first: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_load.power_on) |-> o_load.strobe && o_load.load_all)
        else $error("power-on load not a full load");
    a_cmd_partial: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_cmd_reset && !s_reg.pon_pend) |=> o_load.strobe && !o_load.load_all
        && o_load.status_word == STATUS_WORD_INIT && o_load.pc == $past(i_pc_vec))
        else $error("command reset load wrong");

endmodule : reg_init_loader

// File: dv/user_target_model.sv
// user target system model: drives the active-low control pins
// assumes the bench asks for each pin by one request bit, high = asserted
`timescale 1ns/10ps
module user_target_model
    import break_gating_pkg::*;
(
    input wire logic i_clk,
    input wire logic [2:0] i_req,
    output logic o_reset_n,
    output logic o_bus_request_in_n,
    output logic o_wait_n
);
    // pins idle high until the first request
    initial begin
        o_reset_n = 1'b1;
        o_bus_request_in_n = 1'b1;
        o_wait_n = 1'b1;
    end
    // pins move just after an edge and hold until the next request
    always @(posedge i_clk) begin
        o_reset_n <= !i_req[PIN_RST];
        o_bus_request_in_n <= !i_req[PIN_BUS_REQUEST_IN];
        o_wait_n <= !i_req[PIN_WAIT];
    end
endmodule : user_target_model

// File: dv/emulator_break_gating_tb.sv
// self-checking bench of the emulator break gating block
// assumes zero-wait apb and the user target model on the control pins
`timescale 1ns/10ps
module emulator_break_gating_tb;
    import break_gating_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic pready, pslverr, hit = 1'b0, sdone = 1'b0, e;
    logic [2:0] req = 3'h0, pins_n;
    logic rst_n, bus_request_in_n, wait_n, brk, ube, prun, tick, ovf, tu, te, su, se;
    logic [IRQ_W-1:0] irq_src = 4'h0, irq;
    logic [31:0] pc_vec = 32'h00001000, sp_vec = 32'h00002000;
    logic [7:0] cnt, held;
    reg_load_t ld;
    int miscompares = 0, check_count = 0;
    user_target_model user_target_model_i (.i_clk(clk), .i_req(req), .o_reset_n(pins_n[0]),
        .o_bus_request_in_n(pins_n[1]), .o_wait_n(pins_n[2]));
    emulator_break_gating emulator_break_gating_i (.I_CLK(clk), .I_RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .I_BREAK_HIT(hit), .I_STEP_DONE(sdone),
        .I_EXT_RESET_IN_N(pins_n[0]), .I_BUS_REQUEST_IN_N(pins_n[1]),
        .I_WAIT_IN_N(pins_n[2]), .O_MCU_RESET_N(rst_n), .O_MCU_BUS_REQUEST_N(bus_request_in_n),
        .O_MCU_WAIT_N(wait_n), .I_IRQ_SRC(irq_src), .O_MCU_IRQ(irq),
        .I_PON_PC_VEC(pc_vec), .I_PON_SP_VEC(sp_vec), .O_REG_LOAD(ld), .O_BREAK(brk),
        .O_USER_BREAK_EN(ube), .O_PERIPH_RUN(prun), .O_GUARD_TICK(tick), .O_GUARD_OVF(ovf),
        .O_GUARD_COUNT(cnt), .O_TRACE_USER_EN(tu), .O_TRACE_EMU_EN(te),
        .O_SDBG_USER_EN(su), .O_SDBG_EMU_EN(se));
    // 40 MHz clock
    always #12.5 clk = !clk;
    // ***************************************************************
    // shared tasks
    // ***************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the watchdog ends a wait that never gets an answer
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // expected pass pattern of the three pins for a mode and disable setting
    function automatic logic [2:0] pass_exp(input logic [1:0] m, input logic [2:0] dis);
        logic rl;
        rl = (m == EMU_RUN) || (m == EMU_STEP);
        pass_exp[PIN_RST] = (m == EMU_RUN) && !dis[0];
        pass_exp[PIN_BUS_REQUEST_IN] = (m == EMU_MEMACC) || (rl && !dis[1]);
        pass_exp[PIN_WAIT] = (m == EMU_MEMACC) || (rl && !dis[2]);
    endfunction : pass_exp
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_power_on();
        for (int n = 0; n < 6 && ld.strobe !== 1'b1; n++) @(negedge clk);
        chk(ld.strobe, 1'b1);
        chk({ld.power_on, ld.load_all}, 2'b11);
        chk(ld.pc, pc_vec);
        chk(ld.sp, sp_vec);
        chk(ld.status_word, 32'h000000f0);
        chk(ld.vector_base_pointer | ld.global_base_pointer | ld.gpr_value, 32'h0);
        chk(ld.multiply_acc_high | ld.multiply_acc_low | ld.return_pointer, 32'h0);
        chk({brk, su, se, prun}, 4'b1011);
        $display("power-on load done");
    endtask : t_power_on
    task automatic t_gating();
        logic [2:0] dis;
        logic [2:0] p;
        req <= 3'h7;
        for (int k = 0; k < 8; k++) begin
            dis = (k < 4) ? 3'h0 : 3'h7;
            apb(1'b1, CTRL_OFS, 32'(k % 4) | (32'(dis) << CTRL_DIS_LSB));
            settle(8);
            p = pass_exp(2'(k % 4), dis);
            chk({wait_n, bus_request_in_n, rst_n}, 3'(~p));
        end
        req <= 3'h0;
        settle(8);
        chk({wait_n, bus_request_in_n, rst_n}, PIN_IDLE_VAL);
        $display("pin gating done");
    endtask : t_gating
    task automatic t_guard();
        int n_tick;
        // a break hit in memory access mode is ignored
        @(posedge clk);
        hit <= 1'b1;
        @(posedge clk);
        hit <= 1'b0;
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(q[1:0], 2'(EMU_MEMACC));
        apb(1'b1, GUARD_CFG_OFS, 32'h1);
        apb(1'b1, CTRL_OFS, 32'(EMU_RUN));
        settle(20);
        chk(ube, 1'b1);
        @(posedge clk);
        hit <= 1'b1;
        @(posedge clk);
        hit <= 1'b0;
        settle(1);
        held = cnt;
        chk({brk, ube, prun}, 3'b101);
        // prescaler keeps ticking every second clock while the count is frozen
        n_tick = 0;
        repeat (20) begin
            @(negedge clk);
            if (tick === 1'b1) n_tick++;
        end
        chk(n_tick, 10);
        chk(cnt, held);
        apb(1'b1, CTRL_OFS, 32'(EMU_RUN));
        for (int n = 0; n < 10 && cnt === held; n++) @(negedge clk);
        chk(cnt, 8'(held + 8'h1));
        // tick every clock until the counter wraps
        apb(1'b1, GUARD_CFG_OFS, 32'h0);
        for (int n = 0; n < 300 && ovf !== 1'b1; n++) @(negedge clk);
        chk({ovf, cnt}, 9'h100);
        apb(1'b1, CTRL_OFS, 32'(EMU_BREAK));
        $display("guard freeze done");
    endtask : t_guard
    task automatic t_irq();
        @(posedge clk);
        irq_src <= 4'h5;
        @(posedge clk);
        irq_src <= 4'h0;
        settle(2);
        chk(irq, 4'h0);
        apb(1'b1, CTRL_OFS, 32'(EMU_RUN));
        for (int n = 0; n < 4 && irq === 4'h0; n++) @(negedge clk);
        chk(irq, 4'h5);
        apb(1'b1, CTRL_OFS, 32'(EMU_BREAK));
        $display("held interrupt done");
    endtask : t_irq
    task automatic t_trace();
        apb(1'b1, CTRL_OFS, 32'h1 << CTRL_TRACE_BIT);
        settle(1);
        chk({tu, te, su, se}, 4'b0101);
        apb(1'b1, CTRL_OFS, 32'h0);
        settle(1);
        chk({tu, te}, 2'b10);
        $display("trace claim done");
    endtask : t_trace
    task automatic t_cmd_reset();
        apb(1'b1, CTRL_OFS, (32'h1 << CTRL_CPURST_BIT) | 32'(EMU_RUN));
        for (int n = 0; n < 6 && ld.strobe !== 1'b1; n++) @(negedge clk);
        chk({ld.strobe, ld.power_on, ld.load_all}, 3'b100);
        chk(ld.status_word, 32'h000000f0);
        chk(ld.vector_base_pointer, 32'h0);
        chk(ld.pc, pc_vec);
        chk(ld.sp, sp_vec);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(q[CTRL_CPURST_BIT], 1'b0);
        $display("command reset done");
    endtask : t_cmd_reset
    task automatic t_map();
        apb(1'b1, CTRL_OFS, 32'(EMU_STEP));
        @(posedge clk);
        sdone <= 1'b1;
        @(posedge clk);
        sdone <= 1'b0;
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(q[2:0], 3'b100);
        apb(1'b0, 8'h0c, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0);
        $display("register map done");
    endtask : t_map
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // watchdog against a hang
    initial begin
        #125000;
        miscompares++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_power_on();
        t_gating();
        t_guard();
        t_irq();
        t_trace();
        t_cmd_reset();
        t_map();
        end_of_test();
    end
endmodule : emulator_break_gating_tb
